// >>> include/ccfg_consts.vh
// Constants for the core configuration and event counter block
`ifndef CCFG_CONSTS_VH
`define CCFG_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CCFG_OFS_CONFIG 4'h0
`define CCFG_OFS_CNT1 4'h4
`define CCFG_OFS_CNT2 4'h8
`define CCFG_OFS_STATUS 4'hC

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define CCFG_CFG_RESET 32'h00000000
`define CCFG_B_C2_IRQ_EN 31
`define CCFG_B_C2_KERN_ONLY 30
`define CCFG_F_C2_SEL_HI 29
`define CCFG_F_C2_SEL_LO 25
`define CCFG_B_C1_IRQ_EN 24
`define CCFG_B_C1_KERN_ONLY 23
`define CCFG_B_C1_INSN_SEL 22
`define CCFG_B_PF_OFFCHIP 21
`define CCFG_B_PF_BUF_EN 20
`define CCFG_B_ICACHE_EN 19
`define CCFG_B_SCACHE_EN 18
`define CCFG_B_ADDR_EXT 17
`define CCFG_B_KERN_LE 16
`define CCFG_RSVD_ZERO 16'h0000

// ----------------------------------------
// Second counter event codes
// ----------------------------------------
`define CCFG_EV_CLOCK 5'h00
`define CCFG_EV_INSN 5'h01
`define CCFG_EV_HOLD 5'h1F

// ----------------------------------------
// Counter, vector and status encodings
// ----------------------------------------
`define CCFG_CNT_ONES 32'hFFFFFFFF
`define CCFG_CNT_RESET 32'h00000000
`define CCFG_KERNEL_LEVEL 1'h0
`define CCFG_VEC_NONE 2'h0
`define CCFG_VEC_EXT 2'h1
`define CCFG_VEC_CNT1 2'h2
`define CCFG_VEC_CNT2 2'h3
`define CCFG_B_ST_PEND1 0
`define CCFG_B_ST_PEND2 1
`define CCFG_B_ST_KERNEL 2

`endif

// >>> hw/ccfg_counter.v
// Free-running 32-bit event counter with wrap pulse
`timescale 1ns/1ps
`include "ccfg_consts.vh"

module ccfg_counter (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Count control
	input wire inc,
	// Results
	output reg [31:0] count_r,
	output reg wrap_r
);

	// ----------------------------------------
	// Counting
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			count_r <= `CCFG_CNT_RESET;
			wrap_r <= 1'b0;
		end else begin
			wrap_r <= inc && (count_r == `CCFG_CNT_ONES);
			if (inc) begin
				count_r <= count_r + 32'h00000001;
			end
		end
	end

endmodule

// >>> hw/ccfg_irq_arb.v
// Level one interrupt pending flags and priority selection
`timescale 1ns/1ps
`include "ccfg_consts.vh"

module ccfg_irq_arb (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Requests
	input wire ext_req,
	input wire c1_wrap,
	input wire c1_irq_en,
	input wire c2_wrap,
	input wire c2_irq_en,
	// Acknowledge from the core
	input wire irq_ack,
	// Results
	output reg pend1_r,
	output reg pend2_r,
	output reg irq_r,
	output reg [1:0] vec_r
);

	reg [1:0] vec_nxt;

	// ----------------------------------------
	// Priority: external, then first, then second
	// ----------------------------------------
	always @* begin
		if (ext_req) begin
			vec_nxt = `CCFG_VEC_EXT;
		end else if (pend1_r) begin
			vec_nxt = `CCFG_VEC_CNT1;
		end else if (pend2_r) begin
			vec_nxt = `CCFG_VEC_CNT2;
		end else begin
			vec_nxt = `CCFG_VEC_NONE;
		end
	end

	// ----------------------------------------
	// Sticky flags; a wrap wins over the ack
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			pend1_r <= 1'b0;
			pend2_r <= 1'b0;
			irq_r <= 1'b0;
			vec_r <= `CCFG_VEC_NONE;
		end else begin
			if (c1_wrap && c1_irq_en) begin
				pend1_r <= 1'b1;
			end else if (irq_ack && vec_r == `CCFG_VEC_CNT1) begin
				pend1_r <= 1'b0;
			end
			if (c2_wrap && c2_irq_en) begin
				pend2_r <= 1'b1;
			end else if (irq_ack && vec_r == `CCFG_VEC_CNT2) begin
				pend2_r <= 1'b0;
			end
			irq_r <= (vec_nxt != `CCFG_VEC_NONE) && !irq_ack;
			vec_r <= irq_ack ? `CCFG_VEC_NONE : vec_nxt;
		end
	end

endmodule

// >>> hw/ccfg_top.v
// Core configuration register with two event counters and control outputs
`timescale 1ns/1ps
`include "ccfg_consts.vh"

module ccfg_top (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Register bus
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Core status
	input wire psw_exec_level,
	input wire psw_user_le,
	input wire insn_done,
	input wire folded_branch,
	// Interrupts
	input wire ext_l1_req,
	input wire irq_ack,
	output wire irq_l1,
	output wire [1:0] irq_vec_sel,
	// Fetch and cache gating
	input wire pf_buf_hit,
	input wire icache_req,
	input wire scache_req,
	output reg pf_offchip_en_r,
	output reg pf_buf_hit_ok_r,
	output reg icache_ok_r,
	output reg scache_ok_r,
	// Address extension and byte order
	input wire [15:0] abs_addr16,
	input wire [31:0] pc,
	output reg [31:0] ext_addr_r,
	output reg data_le_r
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Privilege gate: free in all modes or kernel only
	function priv_ok;
		input kern_only;
		input kern;
		begin
			priv_ok = !kern_only || kern;
		end
	endfunction

	// Completed instruction, folded branches excluded
	function insn_event;
		input done;
		input folded;
		begin
			insn_event = done && !folded;
		end
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg [31:16] cfg_r;
	reg [31:16] cfg_nxt;
	reg ack_r;
	reg [31:0] rd_nxt;
	reg ext_s1_r;
	reg ext_s2_r;
	reg c1_inc;
	reg c2_inc;
	wire kernel;
	wire insn_ev;
	wire [4:0] c2_sel;
	wire [31:0] cnt1;
	wire [31:0] cnt2;
	wire wrap1;
	wire wrap2;
	wire pend1;
	wire pend2;
	wire bus_req;
	wire bus_take;
	localparam [31:0] cfg_reset_word = `CCFG_CFG_RESET;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	assign kernel = (psw_exec_level == `CCFG_KERNEL_LEVEL);
	assign insn_ev = insn_event(insn_done, folded_branch);
	assign c2_sel = cfg_r[`CCFG_F_C2_SEL_HI:`CCFG_F_C2_SEL_LO];

	// ----------------------------------------
	// External request synchroniser
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_l1_req;
			ext_s2_r <= ext_s1_r;
		end
	end

	// ----------------------------------------
	// Counter increment selection
	// ----------------------------------------
	always @* begin
		// First counter
		if (!priv_ok(cfg_r[`CCFG_B_C1_KERN_ONLY], kernel)) begin
			c1_inc = 1'b0;
		end else if (cfg_r[`CCFG_B_C1_INSN_SEL]) begin
			c1_inc = insn_ev;
		end else begin
			c1_inc = 1'b1;
		end
		// Second counter
		c2_inc = 1'b0;
		if (priv_ok(cfg_r[`CCFG_B_C2_KERN_ONLY], kernel)) begin
			case (c2_sel)
				`CCFG_EV_CLOCK: begin
					c2_inc = 1'b1;
				end
				`CCFG_EV_INSN: begin
					c2_inc = insn_ev;
				end
				`CCFG_EV_HOLD: begin
					c2_inc = 1'b0;
				end
				default: begin
					c2_inc = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	ccfg_counter u_cnt1 (
		.clk(clk),
		.rst(rst),
		.inc(c1_inc),
		.count_r(cnt1),
		.wrap_r(wrap1)
	);

	ccfg_counter u_cnt2 (
		.clk(clk),
		.rst(rst),
		.inc(c2_inc),
		.count_r(cnt2),
		.wrap_r(wrap2)
	);

	// ----------------------------------------
	// Interrupt priority
	// ----------------------------------------
	ccfg_irq_arb u_arb (
		.clk(clk),
		.rst(rst),
		.ext_req(ext_s2_r),
		.c1_wrap(wrap1),
		.c1_irq_en(cfg_r[`CCFG_B_C1_IRQ_EN]),
		.c2_wrap(wrap2),
		.c2_irq_en(cfg_r[`CCFG_B_C2_IRQ_EN]),
		.irq_ack(irq_ack),
		.pend1_r(pend1),
		.pend2_r(pend2),
		.irq_r(irq_l1),
		.vec_r(irq_vec_sel)
	);

	// ----------------------------------------
	// Bus handshake: one wait cycle per access
	// ----------------------------------------
	assign bus_req = avs_read || avs_write;
	assign bus_take = bus_req && !ack_r;
	assign avs_waitrequest = bus_req && !ack_r;

	always @(posedge clk) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_take;
		end
	end

	// ----------------------------------------
	// Configuration write, upper two byte lanes
	// ----------------------------------------
	always @* begin
		cfg_nxt = cfg_r;
		if (bus_take && avs_write && avs_address == `CCFG_OFS_CONFIG) begin
			if (avs_byteenable[3]) begin
				cfg_nxt[31:24] = avs_writedata[31:24];
			end
			if (avs_byteenable[2]) begin
				cfg_nxt[23:16] = avs_writedata[23:16];
			end
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			cfg_r <= cfg_reset_word[31:16];
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @* begin
		rd_nxt = 32'h00000000;
		case (avs_address)
			`CCFG_OFS_CONFIG: begin
				rd_nxt = {cfg_r, `CCFG_RSVD_ZERO};
			end
			`CCFG_OFS_CNT1: begin
				rd_nxt = cnt1;
			end
			`CCFG_OFS_CNT2: begin
				rd_nxt = cnt2;
			end
			`CCFG_OFS_STATUS: begin
				rd_nxt[`CCFG_B_ST_PEND1] = pend1;
				rd_nxt[`CCFG_B_ST_PEND2] = pend2;
				rd_nxt[`CCFG_B_ST_KERNEL] = kernel;
			end
			default: begin
				rd_nxt = 32'h00000000;
			end
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (bus_take && avs_read) begin
			avs_readdata <= rd_nxt;
		end
	end

	// ----------------------------------------
	// Fetch, cache gating, address and byte order
	// ----------------------------------------
	// Enables only gate use; nothing here touches stored contents
	always @(posedge clk) begin
		if (rst) begin
			pf_offchip_en_r <= 1'b0;
			pf_buf_hit_ok_r <= 1'b0;
			icache_ok_r <= 1'b0;
			scache_ok_r <= 1'b0;
			ext_addr_r <= 32'h00000000;
			data_le_r <= 1'b0;
		end else begin
			pf_offchip_en_r <= cfg_r[`CCFG_B_PF_OFFCHIP];
			pf_buf_hit_ok_r <= pf_buf_hit && cfg_r[`CCFG_B_PF_BUF_EN];
			icache_ok_r <= icache_req && cfg_r[`CCFG_B_ICACHE_EN];
			scache_ok_r <= scache_req && cfg_r[`CCFG_B_SCACHE_EN];
			if (cfg_r[`CCFG_B_ADDR_EXT]) begin
				ext_addr_r <= {pc[31:29], 13'h0, abs_addr16};
			end else begin
				ext_addr_r <= {16'h0000, abs_addr16};
			end
			if (kernel) begin
				data_le_r <= cfg_r[`CCFG_B_KERN_LE];
			end else begin
				data_le_r <= psw_user_le;
			end
		end
	end

endmodule

// >>> sim/ccfg_top_checker.sv
// Port level checks for the core configuration block
`timescale 1ns/1ps
module ccfg_top_checker (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Register bus
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_waitrequest,
	input wire [31:0] avs_readdata,
	// Core side
	input wire psw_exec_level,
	input wire psw_user_le,
	input wire ext_l1_req,
	input wire irq_l1,
	input wire [1:0] irq_vec_sel,
	input wire pf_buf_hit,
	input wire icache_req,
	input wire scache_req,
	input wire pf_offchip_en_r,
	input wire pf_buf_hit_ok_r,
	input wire icache_ok_r,
	input wire scache_ok_r,
	input wire [15:0] abs_addr16,
	input wire [31:0] ext_addr_r,
	input wire data_le_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence ext_held_s;
		ext_l1_req [*5];
	endsequence
	sequence cfg_read_s;
		avs_read && avs_waitrequest && avs_address == 4'h0 ##1 1'h1;
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	rsvd_zero_a: assert property (cfg_read_s |-> avs_readdata[15:0] == 16'h0000)
		else $error("Reserved config bits read nonzero");
	pf_gate_a: assert property (pf_buf_hit_ok_r |-> $past(pf_buf_hit))
		else $error("Prefetch hit granted without request");
	ic_gate_a: assert property (icache_ok_r |-> $past(icache_req))
		else $error("Icache grant without request");
	sc_gate_a: assert property (scache_ok_r |-> $past(scache_req))
		else $error("Stack cache grant without request");
	addr_ext_a: assert property (!$past(rst) |-> ext_addr_r[28:16] == 13'h0000 &&
		ext_addr_r[15:0] == $past(abs_addr16)) else $error("Extended address wrong");
	irq_vec_a: assert property (irq_l1 |-> irq_vec_sel != 2'h0)
		else $error("Interrupt without vector");
	ext_first_a: assert property (ext_held_s ##1 irq_l1 |-> irq_vec_sel == 2'h1)
		else $error("External request not first");
	user_order_a: assert property (!$past(rst) && $past(psw_exec_level) |->
		data_le_r == $past(psw_user_le)) else $error("User byte order wrong");
	reset_off_a: assert property (disable iff (1'h0) rst |=> !pf_offchip_en_r [*2])
		else $error("Prefetch enable set after reset");
endmodule

// >>> sim/ccfg_top_test.sv
// Self-checking testbench for the core configuration block
`timescale 1ns/1ps
module ccfg_top_test;
	reg clk;
	reg rst = 1'h1;
	reg [3:0] avs_address = 4'h0;
	reg [3:0] avs_byteenable = 4'hF;
	reg avs_read = 1'h0, avs_write = 1'h0, psw_exec_level = 1'h0, psw_user_le = 1'h0;
	reg insn_done = 1'h0, folded_branch = 1'h0, ext_l1_req = 1'h0, irq_ack = 1'h0;
	reg pf_buf_hit = 1'h0, icache_req = 1'h0, scache_req = 1'h0;
	reg [31:0] avs_writedata = 32'h0, pc = 32'h0, q1, q2, v;
	reg [15:0] abs_addr16 = 16'h0;
	wire [31:0] avs_readdata, ext_addr_r;
	wire avs_waitrequest, irq_l1, pf_offchip_en_r, pf_buf_hit_ok_r;
	wire icache_ok_r, scache_ok_r, data_le_r;
	wire [1:0] irq_vec_sel;
	integer fails = 0, samples_checked = 0, seed = 73827, i;
	reg [32:0] expq[$];
	reg [32:0] e_r;
	ccfg_top ccfg_top_i (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .psw_exec_level, .psw_user_le,
		.insn_done, .folded_branch, .ext_l1_req, .irq_ack, .irq_l1, .irq_vec_sel,
		.pf_buf_hit, .icache_req, .scache_req, .pf_offchip_en_r, .pf_buf_hit_ok_r,
		.icache_ok_r, .scache_ok_r, .abs_addr16, .pc, .ext_addr_r, .data_le_r);
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task tally_and_finish;
		begin
			$display("checked %0d mismatches %0d", samples_checked, fails);
			if (fails == 0 && samples_checked > 0) begin
				$display("Simulation passed");
			end else begin
				$display("Simulation failed");
			end
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] x);
		begin
			samples_checked = samples_checked + 1;
			if (g !== x) begin
				fails = fails + 1;
				$display("ERROR %0t got %h expected %h", $time, g, x);
			end
		end
	endtask
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'h0 && expq.size() > 0) begin
			e_r = expq.pop_front();
			if (e_r[32]) chk(avs_readdata, e_r[31:0]);
		end
	end
	task bus(input w, input [3:0] a, input [31:0] d, input u, input [31:0] x,
		output [31:0] q);
		integer n;
		begin
			n = 0;
			q = 32'h0;
			@(posedge clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_read <= ~w;
			avs_write <= w;
			if (!w) expq.push_back({u, x});
			// Sample waitrequest at each rising edge; release only after it is low
			do begin
				@(posedge clk);
				n = n + 1;
			end while (avs_waitrequest !== 1'h0 && n < 50);
			if (avs_waitrequest !== 1'h0) begin
				fails = fails + 1;
				$display("ERROR %0t bus wait timed out", $time);
				tally_and_finish;
			end else begin
				q = avs_readdata;
				avs_read <= 1'h0;
				avs_write <= 1'h0;
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		bus(1'h1, a, d, 1'h0, 32'h0, q1);
	endtask
	task rd(input [3:0] a, input [31:0] x);
		bus(1'h0, a, 32'h0, 1'h1, x, q1);
	endtask
	task cnt(input [31:0] c, input lv, input dn, input fb, input [3:0] a, input [31:0] d);
		begin
			psw_exec_level <= lv;
			insn_done <= dn;
			folded_branch <= fb;
			wr(4'h0, c);
			bus(1'h0, a, 32'h0, 1'h0, 32'h0, q1);
			bus(1'h0, a, 32'h0, 1'h0, 32'h0, q2);
			chk(q2 - q1, d);
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		rd(4'h0, 32'h0);
		wr(4'h0, 32'hFFFFFFFF);
		rd(4'h0, 32'hFFFF0000);
		avs_byteenable <= 4'h4;
		wr(4'h0, 32'h0);
		avs_byteenable <= 4'hF;
		rd(4'h0, 32'hFF000000);
		wr(4'h2, 32'h12345678);
		rd(4'h2, 32'h0);
		rd(4'h0, 32'hFF000000);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(4'h0, 32'h0);
		$display("register test done");
		cnt(32'h00000000, 1'h1, 1'h0, 1'h0, 4'h4, 32'h3);
		cnt(32'h00800000, 1'h1, 1'h0, 1'h0, 4'h4, 32'h0);
		cnt(32'h00800000, 1'h0, 1'h0, 1'h0, 4'h4, 32'h3);
		cnt(32'h00400000, 1'h0, 1'h1, 1'h1, 4'h4, 32'h0);
		cnt(32'h00400000, 1'h0, 1'h1, 1'h0, 4'h4, 32'h3);
		cnt(32'h00000000, 1'h0, 1'h0, 1'h0, 4'h8, 32'h3);
		cnt(32'h3E000000, 1'h0, 1'h1, 1'h0, 4'h8, 32'h0);
		cnt(32'h02000000, 1'h0, 1'h1, 1'h0, 4'h8, 32'h3);
		cnt(32'h02000000, 1'h0, 1'h1, 1'h1, 4'h8, 32'h0);
		cnt(32'h40000000, 1'h1, 1'h0, 1'h0, 4'h8, 32'h0);
		$display("counter test done");
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge clk);
			v = i ? 32'hFFFF0000 : 32'h0;
			pc <= $random(seed);
			q2 = $random(seed);
			abs_addr16 <= q2[15:0];
			psw_user_le <= q2[20];
			psw_exec_level <= 1'h0;
			pf_buf_hit <= 1'h1;
			icache_req <= 1'h1;
			scache_req <= 1'h1;
			wr(4'h0, v);
			@(negedge clk);
			@(negedge clk);
			chk(pf_offchip_en_r, v[21]);
			chk(pf_buf_hit_ok_r, v[20]);
			chk(icache_ok_r, v[19]);
			chk(scache_ok_r, v[18]);
			chk(ext_addr_r, {v[17] ? pc[31:29] : 3'h0, 13'h0, abs_addr16});
			chk(data_le_r, v[16]);
		end
		$display("gating test done");
		@(posedge clk);
		ext_l1_req <= 1'h1;
		repeat (6) @(posedge clk);
		irq_ack <= 1'h1;
		@(posedge clk);
		irq_ack <= 1'h0;
		repeat (6) @(negedge clk);
		chk(irq_l1, 32'h1);
		chk(irq_vec_sel, 32'h1);
		@(posedge clk);
		ext_l1_req <= 1'h0;
		repeat (6) @(negedge clk);
		chk(irq_l1, 32'h0);
		$display("interrupt test done");
		tally_and_finish;
	end
endmodule
bind ccfg_top ccfg_top_checker ccfg_top_checker_i (.clk, .rst, .avs_address, .avs_read,
	.avs_waitrequest, .avs_readdata, .psw_exec_level, .psw_user_le, .ext_l1_req, .irq_l1,
	.irq_vec_sel, .pf_buf_hit, .icache_req, .scache_req, .pf_offchip_en_r, .pf_buf_hit_ok_r,
	.icache_ok_r, .scache_ok_r, .abs_addr16, .ext_addr_r, .data_le_r);
